// ---- pid_reg_pkg.sv ----
// constants, register map and carrier types for the process pid regulator
// assumes a 100 MHz clock and a 32-bit ahb-lite register bus
package pid_reg_pkg;

   // register byte offsets, one aligned word each
   localparam logic [7:0] OFS_SP_SRC     = 8'h00;
   localparam logic [7:0] OFS_SP_PARAM   = 8'h04;
   localparam logic [7:0] OFS_FB_SRC     = 8'h08;
   localparam logic [7:0] OFS_DIRECTION  = 8'h0C;
   localparam logic [7:0] OFS_RANGE      = 8'h10;
   localparam logic [7:0] OFS_KP         = 8'h14;
   localparam logic [7:0] OFS_TI         = 8'h18;
   localparam logic [7:0] OFS_TD         = 8'h1C;
   localparam logic [7:0] OFS_REV_CUT    = 8'h20;
   localparam logic [7:0] OFS_DEV_LIMIT  = 8'h24;
   localparam logic [7:0] OFS_DIFF_LIMIT = 8'h28;
   localparam logic [7:0] OFS_CHG_TIME   = 8'h2C;
   localparam logic [7:0] OFS_MAX_FREQ   = 8'h30;
   localparam logic [7:0] OFS_COMM_VAL   = 8'h34;
   localparam logic [7:0] OFS_SP_DISP    = 8'h38;
   localparam logic [7:0] OFS_FB_DISP    = 8'h3C;
   localparam logic [7:0] OFS_FREQ_CMD   = 8'h40;

   // reset values
   localparam logic [15:0] RST_SP_PARAM   = 16'h01F4; // 50.0 % in 0.1 %
   localparam logic [15:0] RST_RANGE      = 16'h03E8; // 1000
   localparam logic [15:0] RST_KP         = 16'h00C8; // 20.0
   localparam logic [15:0] RST_TI         = 16'h00C8; // 2.00 s
   localparam logic [15:0] RST_DIFF_LIMIT = 16'h0032; // 0.50 %
   localparam logic [15:0] RST_MAX_FREQ   = 16'h1388; // 50.00 Hz

   // source codes
   localparam logic [3:0] SP_PARAM = 4'h0;
   localparam logic [3:0] SP_AIN1  = 4'h1;
   localparam logic [3:0] SP_AIN2  = 4'h2;
   localparam logic [3:0] SP_PULSE = 4'h4;
   localparam logic [3:0] SP_COMM  = 4'h5;
   localparam logic [3:0] SP_STEP  = 4'h6;
   localparam logic [3:0] FB_AIN1  = 4'h0;
   localparam logic [3:0] FB_AIN2  = 4'h1;
   localparam logic [3:0] FB_DIFF  = 4'h3;
   localparam logic [3:0] FB_PULSE = 4'h4;
   localparam logic [3:0] FB_COMM  = 4'h5;
   localparam logic [3:0] FB_SUM   = 4'h6;
   localparam logic [3:0] FB_MAX   = 4'h7;
   localparam logic [3:0] FB_MIN   = 4'h8;

   // scaling: percent held in 0.01 %, frequency in 0.01 Hz
   localparam logic [15:0] PCT_FULL    = 16'h2710; // 100.00 %
   localparam logic [15:0] PARAM_SCALE = 16'h000A; // 0.1 % to 0.01 %
   localparam logic [63:0] P_DIV       = 64'h0000_0000_0098_9680; // 1000 * 10000
   localparam logic [63:0] I_DIV       = 64'h0000_0000_0001_86A0; // 10 ms * 10000
   localparam logic [63:0] I_MUL       = 64'h0000_0000_0000_0002; // beat in ms
   localparam logic [63:0] D_DIV       = 64'h0000_0000_0000_4E20; // beat ms * 10000
   localparam logic [31:0] RAMP_NUM    = 32'h07D0_0000; // 2000 << 16

   // control beat
   localparam int BEAT_TIME_US  = 2000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int BEAT_CYCLES   = BEAT_TIME_US * 1000 / CLK_PERIOD_NS;

   // software settings carried as one bundle
   typedef struct packed {
      logic [3:0]  sp_src;
      logic [15:0] sp_param;
      logic [3:0]  fb_src;
      logic        direction;
      logic [15:0] range;
      logic [15:0] kp;
      logic [15:0] ti;
      logic [15:0] td;
      logic [15:0] rev_cut;
      logic [15:0] dev_limit;
      logic [15:0] diff_limit;
      logic [15:0] chg_time;
      logic [15:0] max_freq;
      logic [15:0] comm_val;
   } pid_cfg_t;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_RD_WAIT,
      BUS_RD_DATA
   } bus_state_t;

endpackage

// ---- process_pid_regulator.sv ----
// process pid regulator: source select, setpoint ramp, pid terms, output limiting
// assumes analog, pulse and step inputs come from same-clock logic in 0.01 % units;
// the direction-reverse terminal is an asynchronous pin
// Contract
// - setpoint source 0 internal, 1 first analog, 2 second analog, 3 none, 4 pulse, 5 comm, 6 step.
// - setpoint is a 0 to 100 % relative value and the internal setpoint resets to 50.0 %.
// - feedback source 0 a1, 1 a2, 2 none, 3 a1-a2, 4 pulse, 5 comm, 6 sum, 7 max, 8 min.
// - direction 0 raises the frequency command while feedback is below setpoint.
// - direction 1 lowers the frequency command while feedback is below setpoint.
// - the direction-reverse terminal inverts the selected direction while active.
// - display maps 100.0 % to the range setting, 0 to 65535, resetting to 1000.
// - gain 100.0 at 100 % deviation gives max frequency; gain 0 to 999.9, reset 20.0; the kp register takes up to 6553.5 unchecked.
// - integral reaches max frequency after the integration time at 100 %; zero time gives zero.
// - derivative gives max frequency for a 100 % change within the differential time.
// - negative output magnitude is clamped to the reverse cutoff, resetting to 0.00 Hz.
// - while the deviation magnitude is below the deviation limit the output is held.
// - derivative output is clamped to the differential limit, resetting to 0.50 %.
// - setpoint changes ramp linearly over the change time per 100 %; zero steps at once.
// - the regulator updates once per 2 ms control beat.
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
module process_pid_regulator #(
   parameter int BEAT_CYCLES = pid_reg_pkg::BEAT_CYCLES
) (
   input  wire logic               ref_clk_i,
   input  wire logic               arst_n_i,
   input  wire logic               hsel_i,
   input  wire logic [7:0]         haddr_i,
   input  wire logic [1:0]         htrans_i,
   input  wire logic               hwrite_i,
   input  wire logic [2:0]         hsize_i,
   input  wire logic [31:0]        hwdata_i,
   input  wire logic               hready_i,
   output logic      [31:0]        hrdata_o,
   output logic                    hreadyout_o,
   output logic                    hresp_o,
   input  wire logic [15:0]        analog_voltage_input_one_i,
   input  wire logic [15:0]        analog_input_two_i,
   input  wire logic [15:0]        pulse_input_terminal_i,
   input  wire logic [15:0]        multi_step_i,
   input  wire logic               dir_reverse_pin_i,
   output logic signed [16:0]      freq_cmd_o,
   output logic                    beat_o
);

   pid_reg_pkg::pid_cfg_t  cfg;
   pid_reg_pkg::bus_state_t bus_st;
   logic                   rst_s1, rst_n;
   logic                   rev_s1, rev_s2, rev_s3, rev_q;
   logic [31:0]            beat_cnt;
   logic                   beat;
   logic                   wr_ph;
   logic [7:0]             ph_addr;
   logic [15:0]            sp_raw, fb_raw;
   logic [31:0]            ramp, next_ramp, ramp_step, target_fx;
   logic [15:0]            sp_eff, sp_disp, fb_disp;
   logic signed [16:0]     err, prev_err;
   logic signed [31:0]     acc, next_acc;
   logic signed [63:0]     p_term, i_term, d_term, d_lim, sum, next_out;
   logic                   hold, sat_hi, sat_lo, next_sat_hi, next_sat_lo, dir_eff;

   // clamp a relative value to 100.00 %
   function automatic logic [15:0] clamp_pct(input logic [16:0] v);
      clamp_pct = (v > {1'b0, pid_reg_pkg::PCT_FULL}) ? pid_reg_pkg::PCT_FULL : v[15:0];
   endfunction

   // relative value to display units
   function automatic logic [15:0] to_disp(input logic [15:0] v, input logic [15:0] rng);
      logic [31:0] prod;
      prod = v * rng;
      to_disp = 16'(prod / {16'h0000, pid_reg_pkg::PCT_FULL});
   endfunction

   // reset release through two flops
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // three-flop pin filter; level accepted only when the two later stages agree
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rev_s1 <= 1'b0;
         rev_s2 <= 1'b0;
         rev_s3 <= 1'b0;
         rev_q  <= 1'b0;
      end else begin
         rev_s1 <= dir_reverse_pin_i;
         rev_s2 <= rev_s1;
         rev_s3 <= rev_s2;
         if (rev_s2 == rev_s3) begin
            rev_q <= rev_s3;
         end
      end
   end

   // control beat generator
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         beat_cnt <= 32'h0000_0000;
      end else if (beat) begin
         beat_cnt <= 32'h0000_0000;
      end else begin
         beat_cnt <= beat_cnt + 32'h0000_0001;
      end
   end
   assign beat   = (beat_cnt == 32'(BEAT_CYCLES - 1));
   assign beat_o = beat;

   // ahb-lite slave: writes take zero waits, reads one wait so a write just
   // before them is already visible
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         bus_st  <= pid_reg_pkg::BUS_IDLE;
         wr_ph   <= 1'b0;
         ph_addr <= 8'h00;
      end else begin
         wr_ph <= 1'b0;
         case (bus_st)
            pid_reg_pkg::BUS_IDLE, pid_reg_pkg::BUS_RD_DATA: begin
               bus_st <= pid_reg_pkg::BUS_IDLE;
               if (hsel_i && htrans_i[1] && hready_i) begin
                  ph_addr <= haddr_i;
                  wr_ph   <= hwrite_i;
                  if (!hwrite_i) begin
                     bus_st <= pid_reg_pkg::BUS_RD_WAIT;
                  end
               end
            end
            pid_reg_pkg::BUS_RD_WAIT: begin
               bus_st <= pid_reg_pkg::BUS_RD_DATA;
            end
            default: begin
               bus_st <= pid_reg_pkg::BUS_IDLE;
            end
         endcase
      end
   end
   assign hreadyout_o = (bus_st != pid_reg_pkg::BUS_RD_WAIT);
   assign hresp_o     = 1'b0;

   // register writes in the data phase; unmapped offsets are ignored
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cfg            <= '0;
         cfg.sp_param   <= pid_reg_pkg::RST_SP_PARAM;
         cfg.range      <= pid_reg_pkg::RST_RANGE;
         cfg.kp         <= pid_reg_pkg::RST_KP;
         cfg.ti         <= pid_reg_pkg::RST_TI;
         cfg.diff_limit <= pid_reg_pkg::RST_DIFF_LIMIT;
         cfg.max_freq   <= pid_reg_pkg::RST_MAX_FREQ;
      end else if (wr_ph) begin
         case (ph_addr)
            pid_reg_pkg::OFS_SP_SRC:     cfg.sp_src     <= hwdata_i[3:0];
            pid_reg_pkg::OFS_SP_PARAM:   cfg.sp_param   <= hwdata_i[15:0];
            pid_reg_pkg::OFS_FB_SRC:     cfg.fb_src     <= hwdata_i[3:0];
            pid_reg_pkg::OFS_DIRECTION:  cfg.direction  <= hwdata_i[0];
            pid_reg_pkg::OFS_RANGE:      cfg.range      <= hwdata_i[15:0];
            pid_reg_pkg::OFS_KP:         cfg.kp         <= hwdata_i[15:0];
            pid_reg_pkg::OFS_TI:         cfg.ti         <= hwdata_i[15:0];
            pid_reg_pkg::OFS_TD:         cfg.td         <= hwdata_i[15:0];
            pid_reg_pkg::OFS_REV_CUT:    cfg.rev_cut    <= hwdata_i[15:0];
            pid_reg_pkg::OFS_DEV_LIMIT:  cfg.dev_limit  <= hwdata_i[15:0];
            pid_reg_pkg::OFS_DIFF_LIMIT: cfg.diff_limit <= hwdata_i[15:0];
            pid_reg_pkg::OFS_CHG_TIME:   cfg.chg_time   <= hwdata_i[15:0];
            pid_reg_pkg::OFS_MAX_FREQ:   cfg.max_freq   <= hwdata_i[15:0];
            pid_reg_pkg::OFS_COMM_VAL:   cfg.comm_val   <= hwdata_i[15:0];
            default: ;
         endcase
      end
   end

   // read data captured in the wait cycle; unmapped offsets read zero
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_o <= 32'h0000_0000;
      end else if (bus_st == pid_reg_pkg::BUS_RD_WAIT) begin
         case (ph_addr)
            pid_reg_pkg::OFS_SP_SRC:     hrdata_o <= {28'h000_0000, cfg.sp_src};
            pid_reg_pkg::OFS_SP_PARAM:   hrdata_o <= {16'h0000, cfg.sp_param};
            pid_reg_pkg::OFS_FB_SRC:     hrdata_o <= {28'h000_0000, cfg.fb_src};
            pid_reg_pkg::OFS_DIRECTION:  hrdata_o <= {31'h0000_0000, cfg.direction};
            pid_reg_pkg::OFS_RANGE:      hrdata_o <= {16'h0000, cfg.range};
            pid_reg_pkg::OFS_KP:         hrdata_o <= {16'h0000, cfg.kp};
            pid_reg_pkg::OFS_TI:         hrdata_o <= {16'h0000, cfg.ti};
            pid_reg_pkg::OFS_TD:         hrdata_o <= {16'h0000, cfg.td};
            pid_reg_pkg::OFS_REV_CUT:    hrdata_o <= {16'h0000, cfg.rev_cut};
            pid_reg_pkg::OFS_DEV_LIMIT:  hrdata_o <= {16'h0000, cfg.dev_limit};
            pid_reg_pkg::OFS_DIFF_LIMIT: hrdata_o <= {16'h0000, cfg.diff_limit};
            pid_reg_pkg::OFS_CHG_TIME:   hrdata_o <= {16'h0000, cfg.chg_time};
            pid_reg_pkg::OFS_MAX_FREQ:   hrdata_o <= {16'h0000, cfg.max_freq};
            pid_reg_pkg::OFS_COMM_VAL:   hrdata_o <= {16'h0000, cfg.comm_val};
            pid_reg_pkg::OFS_SP_DISP:    hrdata_o <= {16'h0000, sp_disp};
            pid_reg_pkg::OFS_FB_DISP:    hrdata_o <= {16'h0000, fb_disp};
            pid_reg_pkg::OFS_FREQ_CMD:   hrdata_o <= 32'(freq_cmd_o);
            default:                     hrdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // setpoint and feedback source selection; reserved codes give zero
   always_comb begin
      logic [15:0] a1, a2;
      a1 = clamp_pct({1'b0, analog_voltage_input_one_i});
      a2 = clamp_pct({1'b0, analog_input_two_i});
      case (cfg.sp_src)
         pid_reg_pkg::SP_PARAM: sp_raw = clamp_pct(17'(cfg.sp_param * pid_reg_pkg::PARAM_SCALE));
         pid_reg_pkg::SP_AIN1:  sp_raw = a1;
         pid_reg_pkg::SP_AIN2:  sp_raw = a2;
         pid_reg_pkg::SP_PULSE: sp_raw = clamp_pct({1'b0, pulse_input_terminal_i});
         pid_reg_pkg::SP_COMM:  sp_raw = clamp_pct({1'b0, cfg.comm_val});
         pid_reg_pkg::SP_STEP:  sp_raw = clamp_pct({1'b0, multi_step_i});
         default:               sp_raw = 16'h0000;
      endcase
      case (cfg.fb_src)
         pid_reg_pkg::FB_AIN1:  fb_raw = a1;
         pid_reg_pkg::FB_AIN2:  fb_raw = a2;
         pid_reg_pkg::FB_DIFF:  fb_raw = (a1 > a2) ? a1 - a2 : 16'h0000;
         pid_reg_pkg::FB_PULSE: fb_raw = clamp_pct({1'b0, pulse_input_terminal_i});
         pid_reg_pkg::FB_COMM:  fb_raw = clamp_pct({1'b0, cfg.comm_val});
         pid_reg_pkg::FB_SUM:   fb_raw = clamp_pct({1'b0, a1} + {1'b0, a2});
         pid_reg_pkg::FB_MAX:   fb_raw = (a1 > a2) ? a1 : a2;
         pid_reg_pkg::FB_MIN:   fb_raw = (a1 < a2) ? a1 : a2;
         default:               fb_raw = 16'h0000;
      endcase
   end

   // setpoint ramp in 16.16 fixed point; fractional steps keep long times exact
   always_comb begin
      target_fx = {sp_raw, 16'h0000};
      ramp_step = (cfg.chg_time == 16'h0000) ? 32'h0000_0000
                : pid_reg_pkg::RAMP_NUM / {16'h0000, cfg.chg_time};
      if (cfg.chg_time == 16'h0000) begin
         next_ramp = target_fx;
      end else if (ramp < target_fx) begin
         next_ramp = (target_fx - ramp > ramp_step) ? ramp + ramp_step : target_fx;
      end else begin
         next_ramp = (ramp - target_fx > ramp_step) ? ramp - ramp_step : target_fx;
      end
   end
   assign sp_eff  = ramp[31:16];
   assign sp_disp = to_disp(sp_eff, cfg.range);
   assign fb_disp = to_disp(fb_raw, cfg.range);

   // pid terms, computed once per beat in 64-bit arithmetic
   always_comb begin
      logic signed [63:0] fmax, e, de, abs_e;
      fmax    = 64'(signed'({1'b0, cfg.max_freq}));
      dir_eff = cfg.direction ^ rev_q;
      // positive deviation raises output; reverse action flips its sign
      err     = dir_eff ? 17'(signed'({1'b0, fb_raw}) - signed'({1'b0, sp_eff}))
                        : 17'(signed'({1'b0, sp_eff}) - signed'({1'b0, fb_raw}));
      e       = 64'(err);
      abs_e   = (e < 0) ? -e : e;
      hold    = abs_e < 64'(cfg.dev_limit * pid_reg_pkg::PARAM_SCALE);
      p_term  = 64'(signed'({1'b0, cfg.kp})) * e * fmax / signed'(pid_reg_pkg::P_DIV);
      // integral frozen while the sum sits at the +/- max frequency rail it pushes toward
      if (cfg.ti == 16'h0000 || (sat_hi && err > 0) || (sat_lo && err < 0)) begin
         next_acc = (cfg.ti == 16'h0000) ? 32'sh0000_0000 : acc;
      end else begin
         next_acc = acc + 32'(err);
      end
      i_term  = (cfg.ti == 16'h0000) ? 64'sh0
              : 64'(next_acc) * fmax * signed'(pid_reg_pkg::I_MUL)
                / (64'(signed'({1'b0, cfg.ti})) * signed'(pid_reg_pkg::I_DIV));
      de      = e - 64'(prev_err);
      d_term  = de * fmax * 64'(signed'({1'b0, cfg.td})) / signed'(pid_reg_pkg::D_DIV);
      d_lim   = 64'(cfg.diff_limit) * fmax / 64'(pid_reg_pkg::PCT_FULL);
      if (d_term > d_lim) begin
         d_term = d_lim;
      end else if (d_term < -d_lim) begin
         d_term = -d_lim;
      end
      sum         = p_term + i_term + d_term;
      next_sat_hi = sum >= fmax;
      next_sat_lo = sum <= -fmax;
      next_out    = next_sat_hi ? fmax : (next_sat_lo ? -fmax : sum);
      // settings kept signed so negative terms divide and compare as negatives
      if (next_out < -64'(signed'({1'b0, cfg.rev_cut}))) begin
         next_out = -64'(signed'({1'b0, cfg.rev_cut}));
      end
   end

   // beat-paced state update; deadband leaves the output and integral alone
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ramp       <= 32'h0000_0000;
         acc        <= 32'sh0000_0000;
         prev_err   <= 17'sh0_0000;
         sat_hi     <= 1'b0;
         sat_lo     <= 1'b0;
         freq_cmd_o <= 17'sh0_0000;
      end else if (beat) begin
         ramp <= next_ramp;
         if (!hold) begin
            acc        <= next_acc;
            prev_err   <= err;
            sat_hi     <= next_sat_hi;
            sat_lo     <= next_sat_lo;
            freq_cmd_o <= 17'(next_out);
         end
      end
   end

   // checks
   AST_BEAT_PERIOD: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      beat |=> !beat [*2]) else $error("beat repeated too soon");
   AST_OUT_RANGE: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      $rose(beat) |=> (freq_cmd_o <= $signed({1'b0, cfg.max_freq})))
      else $error("output above max frequency");
   AST_REV_CUT: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (beat && !hold && $stable(cfg.rev_cut)) |=> (freq_cmd_o >= -$signed({1'b0, cfg.rev_cut})))
      else $error("reverse output beyond cutoff");
   AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (beat && hold) |=> $stable(freq_cmd_o) && $stable(acc))
      else $error("output moved inside deadband");
   AST_TI_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (cfg.ti == 16'h0000) |-> (i_term == 64'sh0)) else $error("integral nonzero at zero time");
   AST_D_CLAMP: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (d_term <= d_lim) && (d_term >= -d_lim)) else $error("derivative beyond limit");
   AST_RAMP_STEP: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (beat && cfg.chg_time == 16'h0000 && !wr_ph) |=> (sp_eff == $past(sp_raw)))
      else $error("setpoint did not step at zero change time");
   AST_SP_PARAM: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (cfg.sp_src == pid_reg_pkg::SP_PARAM && cfg.sp_param <= 16'h03E8)
      |-> (sp_raw == 16'(cfg.sp_param * pid_reg_pkg::PARAM_SCALE)))
      else $error("internal setpoint wrong");
   AST_DIR_INV: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (!dir_eff && fb_raw < sp_eff) |-> (err > 0)) else $error("positive action sign wrong");
   AST_READ_WAIT: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (hsel_i && htrans_i[1] && hready_i && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait state missing");
   COV_REVERSE: cover property (@(posedge ref_clk_i) disable iff (!rst_n) beat && rev_q && !hold);
   COV_SAT: cover property (@(posedge ref_clk_i) disable iff (!rst_n) beat && next_sat_hi);
   COV_RAMP: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
      beat && cfg.chg_time != 16'h0000 && ramp != target_fx);
   COV_NEG: cover property (@(posedge ref_clk_i) disable iff (!rst_n) freq_cmd_o < 0);

endmodule

// ---- pid_field_model.sv ----
// field side of the regulator: sensor and pulse sources, frequency command consumer
// assumes one clock shared with the regulator and a bench that sets the source levels
module pid_field_model #(
   parameter int BEAT = 20
) (
   input  wire logic               clk_i,
   input  wire logic [63:0]        level_i,
   output logic      [15:0]        ain1_o,
   output logic      [15:0]        ain2_o,
   output logic      [15:0]        pulse_o,
   output logic      [15:0]        step_o,
   input  wire logic               beat_i,
   input  wire logic signed [16:0] freq_i,
   output logic                    bad_o
);
   int                 gap = 0;
   logic               prev_beat = 1'b0;
   logic signed [16:0] last_freq = '0;
   initial bad_o = 1'b0;
   // sensors settle one cycle after the bench moves them, like a sampled converter
   always_ff @(posedge clk_i) {ain1_o, ain2_o, pulse_o, step_o} <= level_i;
   // consumer: the command may move only right after a beat, beats keep their spacing
   always @(posedge clk_i) begin
      gap <= beat_i ? 1 : (gap == 0 ? 0 : gap + 1);
      prev_beat <= beat_i;
      last_freq <= freq_i;
      if (beat_i && gap != 0 && gap != BEAT) bad_o <= 1'b1;
      // only judged once a beat was seen, the command is unknown before reset
      if (freq_i !== last_freq && !prev_beat && gap != 0) bad_o <= 1'b1;
   end
endmodule

// ---- process_pid_regulator_bench.sv ----
// self-checking bench for the process pid regulator, short beat of 20 cycles
// assumes the regulator answers reads after one wait cycle and writes at once
module process_pid_regulator_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BEAT = 20;
   logic               ref_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic               rd_pend = 1'b0, dir_pin = 1'b0, hready, hresp, beat, bad;
   logic [7:0]         haddr = 8'h00;
   logic [1:0]         htrans = 2'b00;
   logic [31:0]        hwdata = '0, hrdata, expv, seed = 32'h0000_784E;
   logic [63:0]        level = '0;
   logic [15:0]        a1, a2, pu, st, cm, e, ain1, ain2, pin, stp;
   logic signed [16:0] freq;
   logic [31:0]        expq[$];
   int                 n_fail = 0, check_count = 0, s1, s2;
   // command read first, before the first beat can move it
   logic [7:0]  ra[14] = '{8'h40, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
                           8'h24, 8'h28, 8'h2C, 8'h00, 8'h80};
   logic [15:0] rv[14] = '{16'h0000, 16'h01F4, 16'h0000, 16'h0000, 16'h03E8, 16'h00C8,
                           16'h00C8, 16'h0000, 16'h0000, 16'h0000, 16'h0032, 16'h0000,
                           16'h0000, 16'h0000};
   logic        dt[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic        pt[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
   logic [15:0] kt[5] = '{16'h00C8, 16'h00C8, 16'h00C8, 16'h00C8, 16'h270F};
   logic [15:0] ct[5] = '{16'h1388, 16'h1388, 16'h1388, 16'h012C, 16'h1388};
   logic [31:0] et[5] = '{32'h0000_01F4, 32'hFFFF_FE0C, 32'hFFFF_FE0C, 32'hFFFF_FED4,
                          32'h0000_1388};
   always #5 ref_clk = ~ref_clk;
   process_pid_regulator #(.BEAT_CYCLES(BEAT)) process_pid_regulator_inst (
      .ref_clk_i(ref_clk), .arst_n_i(arst_n), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .analog_voltage_input_one_i(ain1), .analog_input_two_i(ain2),
      .pulse_input_terminal_i(pin), .multi_step_i(stp), .dir_reverse_pin_i(dir_pin),
      .freq_cmd_o(freq), .beat_o(beat));
   pid_field_model #(.BEAT(BEAT)) pid_field_model_inst (
      .clk_i(ref_clk), .level_i(level), .ain1_o(ain1), .ain2_o(ain2), .pulse_o(pin),
      .step_o(stp), .beat_i(beat), .freq_i(freq), .bad_o(bad));
   // xorshift source kept within 0 to 100.00 %
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return 16'(seed % 32'h0000_2711);
   endfunction
   // one write: address phase held until hready, then data phase until hready
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, 1'b1, a};
      do @(posedge ref_clk); while (hready !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
      do @(posedge ref_clk); while (hready !== 1'b1);
   endtask
   // one read: the expected word is queued for the monitor, which takes it at hready
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      @(posedge ref_clk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, 1'b0, a};
      do @(posedge ref_clk); while (hready !== 1'b1);
      {hsel, htrans, rd_pend} <= {1'b0, 2'b00, 1'b1};
      expq.push_back(x);
      do @(posedge ref_clk); while (hready !== 1'b1);
      rd_pend <= 1'b0;
   endtask
   task automatic beats(input int n);
      repeat (n * BEAT) @(posedge ref_clk);
   endtask
   // wait until n further beats have updated the regulator
   task automatic on_beat(input int n);
      repeat (n) do @(posedge ref_clk); while (beat !== 1'b1);
   endtask
   // monitor: read data is compared at the edge that ends the data phase
   always @(posedge ref_clk) if (rd_pend && hready === 1'b1) begin
      expv = expq.pop_front();
      check_count++;
      if (hrdata !== expv || hresp !== 1'b0) begin
         n_fail++;
         $display("ERROR %0t: read %h expected %h", $time, hrdata, expv);
      end
   end
   task automatic results();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog sized well above the fewer than two thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      $display("ERROR %0t: watchdog expired", $time);
      results();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < 14; i++) rd(ra[i], {16'h0000, rv[i]});
      $display("test reset values done");
      {a1, a2, pu, st, cm} = {rnd(), rnd(), rnd(), rnd(), rnd()};
      level <= {a1, a2, pu, st};
      wr(8'h10, 32'h0000_2710);
      wr(8'h34, {16'h0000, cm});
      wr(8'h18, 32'h0000_0000);
      for (int c = 0; c < 7; c++) begin
         wr(8'h00, 32'(c));
         beats(2);
         case (c)
            0: e = 16'h1388;
            1: e = a1;
            2: e = a2;
            4: e = pu;
            5: e = cm;
            6: e = st;
            default: e = 16'h0000;
         endcase
         rd(8'h38, {16'h0000, e});
      end
      $display("test setpoint sources done");
      for (int c = 0; c < 9; c++) begin
         wr(8'h08, 32'(c));
         beats(2);
         {s1, s2} = {32'(a1), 32'(a2)};
         case (c)
            0: e = a1;
            1: e = a2;
            3: e = 16'(s1 > s2 ? s1 - s2 : 0);
            4: e = pu;
            5: e = cm;
            6: e = 16'(s1 + s2 > 10000 ? 10000 : s1 + s2);
            7: e = 16'(s1 > s2 ? s1 : s2);
            8: e = 16'(s1 < s2 ? s1 : s2);
            default: e = 16'h0000;
         endcase
         rd(8'h3C, {16'h0000, e});
      end
      $display("test feedback sources done");
      // proportional only: 50 % setpoint against zero feedback
      wr(8'h00, 32'h0000_0000);
      wr(8'h08, 32'h0000_0000);
      level <= {16'h0000, a2, pu, st};
      for (int k = 0; k < 5; k++) begin
         wr(8'h0C, {31'h0, dt[k]});
         dir_pin <= pt[k];
         wr(8'h14, {16'h0000, kt[k]});
         wr(8'h20, {16'h0000, ct[k]});
         beats(3);
         rd(8'h40, et[k]);
      end
      $display("test direction and limits done");
      wr(8'h14, 32'h0000_00C8);
      beats(3);
      wr(8'h24, 32'h0000_0258);
      level <= {16'h0FA0, a2, pu, st};
      beats(3);
      rd(8'h40, 32'h0000_01F4);
      $display("test deviation hold done");
      // derivative only: a 40 % feedback drop kicks the output by the 0.50 % limit
      wr(8'h24, 32'h0000_0000);
      wr(8'h14, 32'h0000_0000);
      wr(8'h1C, 32'h0000_0064);
      beats(3);
      level <= {16'h0000, a2, pu, st};
      repeat (2) @(posedge ref_clk);
      on_beat(1);
      rd(8'h40, 32'h0000_0019);
      beats(2);
      rd(8'h40, 32'h0000_0000);
      // integral only: 50 % deviation for 5 beats of a 0.10 s time gives 5 % of max
      wr(8'h18, 32'h0000_000A);
      on_beat(5);
      rd(8'h40, 32'h0000_00FA);
      // ramp of 1.00 s per 100 %: 20 steps of 0.01 % each beat toward 60 %
      wr(8'h2C, 32'h0000_0064);
      wr(8'h04, 32'h0000_0258);
      on_beat(5);
      rd(8'h38, 32'h0000_13EC);
      $display("test derivative, integral and ramp done");
      check_count++;
      if (bad !== 1'b0) begin
         n_fail++;
         $display("ERROR %0t: command moved off the beat", $time);
      end
      results();
   end
endmodule
